// >>> sbc_map.svh
// supervisor constants: timing figures, cycle counts, command layout, reset values
`ifndef SBC_MAP_SVH
`define SBC_MAP_SVH

// clock rate of mclk
`define SBC_CLK_MHZ 100
// reset duration after main supply valid, standard and short variants
`define SBC_T_RSTDUR_MS 15
`define SBC_T_RSTDUR_S_MS 3.5
`define SBC_RSTDUR_CYC (`SBC_T_RSTDUR_MS * 1000 * `SBC_CLK_MHZ)
`define SBC_RSTDUR_S_CYC (`SBC_T_RSTDUR_S_MS * 1000.0 * `SBC_CLK_MHZ)
// over-current deglitch, nominal figure
`define SBC_T_IDD_DGLT_US 55
`define SBC_IDD_DGLT_CYC (`SBC_T_IDD_DGLT_US * `SBC_CLK_MHZ)
// transmit dominant-state timeout, nominal figure
`define SBC_T_DOM_US 360
`define SBC_DOM_CYC (`SBC_T_DOM_US * `SBC_CLK_MHZ)
// level wake filter, nominal figure
`define SBC_T_WUF_US 20
`define SBC_WUF_CYC (`SBC_T_WUF_US * `SBC_CLK_MHZ)
// wake pulse on the interrupt line in stop mode
`define SBC_T_INT_PULSE_US 10
`define SBC_INT_PULSE_CYC (`SBC_T_INT_PULSE_US * `SBC_CLK_MHZ)
// watchdog period and timer wake period, nominal figures
`define SBC_T_WD_US 9750
`define SBC_WD_CYC (`SBC_T_WD_US * `SBC_CLK_MHZ)
`define SBC_T_WAKE_US 4600
`define SBC_WAKE_CYC (`SBC_T_WAKE_US * `SBC_CLK_MHZ)

// serial frame: bits per command, command group field
`define SBC_FRAME_BITS 8
`define SBC_CMD_GRP_HI 7
`define SBC_CMD_GRP_LO 6
`define SBC_GRP_MODE 2'h0
`define SBC_GRP_OUTS 2'h1
`define SBC_GRP_WDOG 2'h2
`define SBC_GRP_INT 2'h3
// field positions inside a command
`define SBC_OUT_HS_BIT 0
`define SBC_OUT_AUX_BIT 1
`define SBC_OUT_TWAKE_BIT 2
`define SBC_WD_TRIG_BIT 0
`define SBC_WD_WIN_BIT 1
`define SBC_WD_CFG_BIT 2
`define SBC_INT_PRE_EN_BIT 0
`define SBC_INT_WAKE_EN_BIT 1
`define SBC_INT_CLR_BIT 3
// reset values
`define SBC_INT_EN_RST 2'h0
`define SBC_WIN_RST 1'b0

`endif

// >>> sbc_pkg.sv
// supervisor types: operating modes
package sbc_pkg;
  typedef enum logic [2:0] {
    SBC_RESET   = 3'b000,
    SBC_NORMAL  = 3'b001,
    SBC_STANDBY = 3'b010,
    SBC_SLEEP   = 3'b011,
    SBC_STOP    = 3'b100
  } sbc_mode_t;
endpackage

// >>> sbc_persist.sv
// persistence filter: output rises once the input has stood high for a set count
`timescale 1ns/10ps
module sbc_persist #(
  parameter int CNT_W = 16,
  parameter logic [CNT_W-1:0] COUNT = 16'h0100
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic level,
  output logic hit
);
  logic [CNT_W-1:0] cnt_q;

  // any low cycle restarts the count, so short glitches never reach hit
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_q <= '0;
      hit <= 1'b0;
    end else if (!level) begin
      cnt_q <= '0;
      hit <= 1'b0;
    end else if (cnt_q == COUNT - 1'b1) begin
      hit <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
endmodule

// >>> sbc_supervisor.sv
// supervisor: reset, thermal, wake, watchdog, serial command port, CAN pin mapping
`timescale 1ns/10ps
`include "sbc_map.svh"
module sbc_supervisor
  import sbc_pkg::*;
#(
  parameter int TMR_W = 24,
  parameter logic [TMR_W-1:0] RSTDUR_CYC = TMR_W'(`SBC_RSTDUR_CYC),
  parameter logic [TMR_W-1:0] RSTDUR_S_CYC = TMR_W'(int'(`SBC_RSTDUR_S_CYC)),
  parameter logic [TMR_W-1:0] WD_CYC = TMR_W'(`SBC_WD_CYC),
  parameter logic [TMR_W-1:0] WAKE_CYC = TMR_W'(`SBC_WAKE_CYC),
  parameter logic [15:0] IDD_DGLT_CYC = 16'(`SBC_IDD_DGLT_CYC),
  parameter logic [15:0] DOM_CYC = 16'(`SBC_DOM_CYC),
  parameter logic [15:0] WUF_CYC = 16'(`SBC_WUF_CYC)
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic short_reset_variant,
  input wire logic vdd_ok,
  input wire logic vdd_overcurrent,
  input wire logic temp_prewarn,
  input wire logic temp_shutdown,
  input wire logic [3:0] level_wake_inputs,
  input wire logic spi_cs_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  input wire logic can_txd,
  input wire logic can_bus_dominant,
  output logic spi_miso,
  output logic spi_miso_oe,
  output logic can_rxd,
  output logic can_drive_dominant,
  output logic rst_out_n,
  output logic int_n,
  output logic wdog_n,
  output logic vdd_enable,
  output logic high_side_switch,
  output logic aux_regulator_drive,
  output logic prewarn_flag
);
  localparam int NSYNC = 13;
  localparam logic [15:0] INT_PULSE_CYC = 16'(`SBC_INT_PULSE_CYC);
  // synchroniser reset matches pin idle levels: cs_n and txd rest high
  localparam logic [NSYNC-1:0] SYNC_IDLE = 13'h0009;

  // two-flop synchronisers for every pin input
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] meta_q;
  logic [NSYNC-1:0] sync_q;
  assign pin_raw = {short_reset_variant, vdd_ok, vdd_overcurrent, temp_prewarn, temp_shutdown,
                    level_wake_inputs, spi_cs_n, spi_sclk, spi_mosi, can_txd};
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_q <= SYNC_IDLE;
      sync_q <= SYNC_IDLE;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
    end
  end
  // bus sense synchronised apart; reset value is recessive
  logic dom_meta_q;
  logic dom_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dom_meta_q <= 1'b0;
      dom_q <= 1'b0;
    end else begin
      dom_meta_q <= can_bus_dominant;
      dom_q <= dom_meta_q;
    end
  end

  wire short_s = sync_q[12];
  wire vdd_ok_s = sync_q[11];
  wire ovc_s = sync_q[10];
  wire hot_s = sync_q[9];
  wire shut_s = sync_q[8];
  wire [3:0] lvl_s = sync_q[7:4];
  wire cs_n_s = sync_q[3];
  wire sclk_s = sync_q[2];
  wire mosi_s = sync_q[1];
  wire txd_s = sync_q[0];

  // deglitch over-current, dominant timeout and level wake filters
  logic ovc_hit;
  logic dom_tout;
  logic [3:0] lvl_hit;
  logic [3:0] lvl_lo_hit;
  logic txd_seen_q;
  sbc_persist #(.CNT_W(16), .COUNT(IDD_DGLT_CYC)) u_ovc (
    .mclk(mclk), .reset_n(reset_n), .level(ovc_s), .hit(ovc_hit));
  // a low txd counts only once the pin has been seen idle high
  sbc_persist #(.CNT_W(16), .COUNT(DOM_CYC)) u_dom (
    .mclk(mclk), .reset_n(reset_n), .level(!txd_s && txd_seen_q), .hit(dom_tout));
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lvl
      sbc_persist #(.CNT_W(16), .COUNT(WUF_CYC)) u_hi (
        .mclk(mclk), .reset_n(reset_n), .level(lvl_s[gi]), .hit(lvl_hit[gi]));
      sbc_persist #(.CNT_W(16), .COUNT(WUF_CYC)) u_lo (
        .mclk(mclk), .reset_n(reset_n), .level(!lvl_s[gi]), .hit(lvl_lo_hit[gi]));
    end
  endgenerate

  // txd counts only after it has been seen high once since reset
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) txd_seen_q <= 1'b0;
    else if (txd_s) txd_seen_q <= 1'b1;
  end

  // serial clock edge detection on the synchronised copy
  logic sclk_d1_q;
  logic cs_d1_q;
  wire sclk_fall = sclk_d1_q && !sclk_s;
  wire sclk_rise = !sclk_d1_q && sclk_s;
  wire cs_fall = cs_d1_q && !cs_n_s;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sclk_d1_q <= 1'b0;
      cs_d1_q <= 1'b1;
    end else begin
      sclk_d1_q <= sclk_s;
      cs_d1_q <= cs_n_s;
    end
  end

  // serial shift registers
  logic [3:0] bit_cnt_q;
  logic [7:0] rx_q;
  logic [7:0] tx_q;
  wire [7:0] rx_next = {rx_q[6:0], mosi_s};
  wire frame_done = !cs_n_s && sclk_fall && (bit_cnt_q == 4'(`SBC_FRAME_BITS - 1));

  sbc_mode_t mode_q;
  logic wd_err_q;
  logic win_q;
  logic wake_flag_q;
  logic [1:0] int_en_q;
  logic twake_en_q;
  wire [7:0] status = {mode_q, prewarn_flag, wake_flag_q, wd_err_q, !vdd_enable, win_q};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
    end else if (cs_n_s) begin
      bit_cnt_q <= '0;
    end else if (cs_fall) begin
      tx_q <= status;
    end else if (sclk_fall) begin
      rx_q <= rx_next;
      bit_cnt_q <= (bit_cnt_q == 4'(`SBC_FRAME_BITS - 1)) ? 4'h0 : bit_cnt_q + 4'h1;
    end else if (sclk_rise && bit_cnt_q != 4'h0) begin
      // first rise keeps the msb loaded at cs fall, so the master sees all 8 bits
      tx_q <= {tx_q[6:0], 1'b0};
    end
  end

  // miso follows the head of the shift register; high impedance outside frames
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      spi_miso <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso <= tx_q[7];
      spi_miso_oe <= !cs_n_s;
    end
  end

  // command decode, acting on the eighth falling clock edge
  wire [1:0] grp = rx_next[`SBC_CMD_GRP_HI:`SBC_CMD_GRP_LO];
  wire cmd_mode = frame_done && grp == `SBC_GRP_MODE;
  wire cmd_outs = frame_done && grp == `SBC_GRP_OUTS;
  wire cmd_wdog = frame_done && grp == `SBC_GRP_WDOG;
  wire cmd_int = frame_done && grp == `SBC_GRP_INT;
  wire running = mode_q == SBC_NORMAL || mode_q == SBC_STANDBY;
  wire low_power = mode_q == SBC_SLEEP || mode_q == SBC_STOP;
  wire wd_trig = cmd_wdog && rx_next[`SBC_WD_TRIG_BIT];
  wire int_clr = cmd_int && rx_next[`SBC_INT_CLR_BIT];

  // shared mode timer: reset duration, watchdog period, wake timer
  logic [TMR_W-1:0] tmr_q;
  wire [TMR_W-1:0] rst_len = short_s ? RSTDUR_S_CYC : RSTDUR_CYC;
  wire rst_done = mode_q == SBC_RESET && vdd_ok_s && tmr_q == rst_len - 1'b1;
  wire wd_early = win_q && tmr_q < (WD_CYC >> 1);
  wire wd_fail = running && ((wd_trig && wd_early) || tmr_q == WD_CYC - 1'b1);
  // gated to low power so the wake timer never restarts the watchdog count
  wire tmr_wake = twake_en_q && low_power && tmr_q == WAKE_CYC - 1'b1;

  // wake sources; level wake is a filtered change from the entry snapshot
  logic [3:0] lvl_snap_q;
  wire [3:0] lvl_changed = (lvl_hit & ~lvl_snap_q) | (lvl_lo_hit & lvl_snap_q);
  wire wake = low_power && (dom_q || |lvl_changed || tmr_wake
              || (mode_q == SBC_STOP && ovc_hit));
  wire uv = !vdd_ok_s && mode_q != SBC_SLEEP && mode_q != SBC_RESET;

  // operating mode machine
  sbc_mode_t mode_d;
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      SBC_RESET: begin
        if (rst_done && vdd_enable) mode_d = SBC_NORMAL;
      end
      SBC_NORMAL, SBC_STANDBY: begin
        if (cmd_mode) mode_d = sbc_mode_t'({1'b0, rx_next[1:0]} + 3'h1);
        if (rx_next[1:0] == 2'h3 && cmd_mode) mode_d = SBC_STOP;
      end
      SBC_SLEEP: begin
        if (wake) mode_d = SBC_RESET;
      end
      SBC_STOP: begin
        if (wake) mode_d = SBC_NORMAL;
      end
      default: mode_d = SBC_RESET;
    endcase
    if (uv || wd_fail || shut_s) mode_d = SBC_RESET;
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) mode_q <= SBC_RESET;
    else mode_q <= mode_d;
  end

  // timer restarts on every mode change, watchdog trigger, and while supply is low in reset mode
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) tmr_q <= '0;
    else if (mode_d != mode_q || wd_trig || (mode_q == SBC_RESET && !vdd_ok_s)) tmr_q <= '0;
    else if (tmr_wake) tmr_q <= '0;
    else tmr_q <= tmr_q + 1'b1;
  end

  // level snapshot taken while running so low power compares against entry state
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) lvl_snap_q <= '0;
    else if (!low_power) lvl_snap_q <= lvl_s;
  end

  // control registers written by command
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      high_side_switch <= 1'b0;
      aux_regulator_drive <= 1'b0;
      twake_en_q <= 1'b0;
      win_q <= `SBC_WIN_RST;
      int_en_q <= `SBC_INT_EN_RST;
    end else begin
      if (mode_q == SBC_RESET || mode_q == SBC_SLEEP) begin
        high_side_switch <= 1'b0;
        aux_regulator_drive <= 1'b0;
      end else if (cmd_outs) begin
        high_side_switch <= rx_next[`SBC_OUT_HS_BIT];
        aux_regulator_drive <= rx_next[`SBC_OUT_AUX_BIT];
        twake_en_q <= rx_next[`SBC_OUT_TWAKE_BIT];
      end
      if (cmd_wdog && rx_next[`SBC_WD_CFG_BIT]) win_q <= rx_next[`SBC_WD_WIN_BIT];
      if (cmd_int) int_en_q <= {rx_next[`SBC_INT_WAKE_EN_BIT], rx_next[`SBC_INT_PRE_EN_BIT]};
    end
  end

  // sticky flags; a new event in the clearing cycle wins over the clear
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prewarn_flag <= 1'b0;
      wake_flag_q <= 1'b0;
      wd_err_q <= 1'b0;
    end else begin
      prewarn_flag <= hot_s || (prewarn_flag && !int_clr);
      wake_flag_q <= wake || (wake_flag_q && !int_clr);
      wd_err_q <= wd_fail || (wd_err_q && !(wd_trig && running));
    end
  end

  // stop-mode wake pulse timer
  logic [15:0] pulse_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) pulse_q <= '0;
    else if (wake && mode_q == SBC_STOP) pulse_q <= INT_PULSE_CYC;
    else if (pulse_q != 16'h0) pulse_q <= pulse_q - 16'h1;
  end

  // pin outputs, all registered
  wire int_level = (int_en_q[0] && prewarn_flag) || (int_en_q[1] && wake_flag_q);
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_out_n <= 1'b0;
      int_n <= 1'b1;
      wdog_n <= 1'b1;
      vdd_enable <= 1'b0;
      can_rxd <= 1'b1;
      can_drive_dominant <= 1'b0;
    end else begin
      rst_out_n <= mode_d != SBC_RESET;
      int_n <= !(int_level || pulse_q != 16'h0);
      wdog_n <= !wd_err_q;
      vdd_enable <= !shut_s && mode_d != SBC_SLEEP;
      can_rxd <= !dom_q;
      // transmitter only active in normal mode
      can_drive_dominant <= mode_q == SBC_NORMAL && !txd_s && txd_seen_q && !dom_tout;
    end
  end
endmodule

// >>> sbc_supervisor_sva.sv
// port-level checks for the supervisor
`timescale 1ns/10ps
module sbc_supervisor_sva #(
  parameter int TMR_W = 24,
  parameter logic [TMR_W-1:0] RSTDUR_CYC = 24'h0000c8,
  parameter logic [TMR_W-1:0] RSTDUR_S_CYC = 24'h000032,
  parameter logic [15:0] DOM_CYC = 16'h0028
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic short_reset_variant,
  input wire logic vdd_ok,
  input wire logic temp_prewarn,
  input wire logic temp_shutdown,
  input wire logic can_txd,
  input wire logic can_bus_dominant,
  input wire logic can_rxd,
  input wire logic can_drive_dominant,
  input wire logic rst_out_n,
  input wire logic vdd_enable,
  input wire logic prewarn_flag
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  logic [TMR_W-1:0] ok_run_q;
  logic [15:0] dom_run_q;

  // run lengths; raw pins lead the synced copies, so lower bounds stay safe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ok_run_q <= '0;
      dom_run_q <= '0;
    end else begin
      ok_run_q <= vdd_ok ? ok_run_q + 1'b1 : '0;
      dom_run_q <= can_drive_dominant ? dom_run_q + 1'b1 : '0;
    end
  end

  rst_dur_a: assert property (
    $rose(rst_out_n) |-> ok_run_q >= (short_reset_variant ? RSTDUR_S_CYC : RSTDUR_CYC))
    else $error("reset released too early");
  rst_uv_a: assert property (
    (vdd_enable && !vdd_ok)[*6] |-> !rst_out_n)
    else $error("reset high with supply low");
  tx_rec_a: assert property (
    can_txd[*5] |-> !can_drive_dominant)
    else $error("bus driven with transmit high");
  tx_limit_a: assert property (
    dom_run_q <= DOM_CYC + 16'h0003)
    else $error("dominant held past timeout");
  rx_dom_a: assert property (
    can_bus_dominant[*4] |-> !can_rxd)
    else $error("receive high on dominant bus");
  rx_rec_a: assert property (
    !can_bus_dominant[*4] |-> can_rxd)
    else $error("receive low on recessive bus");
  vdd_off_a: assert property (
    temp_shutdown[*4] |-> !vdd_enable)
    else $error("regulator on when overheated");
  warn_set_a: assert property (
    temp_prewarn[*4] |-> prewarn_flag)
    else $error("prewarning flag missing");
endmodule

bind sbc_supervisor sbc_supervisor_sva #(.TMR_W(TMR_W), .RSTDUR_CYC(RSTDUR_CYC),
  .RSTDUR_S_CYC(RSTDUR_S_CYC), .DOM_CYC(DOM_CYC)) i_sva (.mclk(mclk), .reset_n(reset_n),
  .short_reset_variant(short_reset_variant), .vdd_ok(vdd_ok), .temp_prewarn(temp_prewarn),
  .temp_shutdown(temp_shutdown), .can_txd(can_txd), .can_bus_dominant(can_bus_dominant),
  .can_rxd(can_rxd), .can_drive_dominant(can_drive_dominant), .rst_out_n(rst_out_n),
  .vdd_enable(vdd_enable), .prewarn_flag(prewarn_flag));

// >>> sbc_mcu_model.sv
// controller stand-in: serial master and CAN transmit pin
`timescale 1ns/10ps
module sbc_mcu_model (
  output logic spi_cs_n,
  output logic spi_sclk,
  output logic spi_mosi,
  output logic can_txd,
  input wire logic spi_miso
);
  // idle: deselected, clock parked low, transmitter recessive
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    can_txd = 1'b1;
  end

  // one 8-bit frame msb first, 125 ns clock
  task automatic xfer(input logic [7:0] b, output logic [7:0] st);
    st = 8'h00;
    spi_cs_n = 1'b0;
    spi_mosi = b[7];
    #62.5;
    for (int i = 7; i >= 0; i--) begin
      spi_sclk = 1'b1;
      spi_mosi = b[i]; // set at rise so it is stable at the sampling fall
      #62.5;
      st[i] = spi_miso;
      spi_sclk = 1'b0;
      #62.5;
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // no stale bit once released
    #62.5;
  endtask
endmodule

// >>> sbc_supervisor_can_timing_test.sv
// supervisor testbench: reset, commands, CAN pins, wakes, watchdog, supply
`timescale 1ns/10ps
`define SBC_CHECK(what, exp, got) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      miscompares++; \
      $display("wrong value %s expected %h seen %h", what, exp, got); \
    end \
  end
module sbc_supervisor_can_timing_test;
  typedef struct {logic [7:0] cmd; logic txd; logic bus; logic hs; logic aux;} sbc_row_t;
  logic mclk, reset_n, short_reset_variant, vdd_ok, vdd_overcurrent, temp_prewarn;
  logic temp_shutdown, spi_cs_n, spi_sclk, spi_mosi, can_txd, can_bus_dominant;
  logic spi_miso, spi_miso_oe, can_rxd, can_drive_dominant, rst_out_n, int_n, wdog_n;
  logic vdd_enable, high_side_switch, aux_regulator_drive, prewarn_flag;
  logic [3:0] level_wake_inputs;
  logic [7:0] stat;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  sbc_row_t rows[4] = '{'{8'h41, 1'b1, 1'b0, 1'b1, 1'b0}, '{8'h42, 1'b0, 1'b1, 1'b0, 1'b1},
    '{8'h43, 1'b0, 1'b0, 1'b1, 1'b1}, '{8'h40, 1'b1, 1'b1, 1'b0, 1'b0}};

  // shortened counts keep the run well under the cycle budget
  sbc_supervisor #(.RSTDUR_CYC(24'h0000c8), .RSTDUR_S_CYC(24'h000032),
    .WD_CYC(24'h0007d0), .IDD_DGLT_CYC(16'h0014),
    .DOM_CYC(16'h0028)) i_dut (.mclk(mclk), .reset_n(reset_n),
    .short_reset_variant(short_reset_variant), .vdd_ok(vdd_ok),
    .vdd_overcurrent(vdd_overcurrent), .temp_prewarn(temp_prewarn),
    .temp_shutdown(temp_shutdown), .level_wake_inputs(level_wake_inputs),
    .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .can_txd(can_txd),
    .can_bus_dominant(can_bus_dominant), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
    .can_rxd(can_rxd), .can_drive_dominant(can_drive_dominant), .rst_out_n(rst_out_n),
    .int_n(int_n), .wdog_n(wdog_n), .vdd_enable(vdd_enable),
    .high_side_switch(high_side_switch), .aux_regulator_drive(aux_regulator_drive),
    .prewarn_flag(prewarn_flag));
  sbc_mcu_model i_mcu (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .can_txd(can_txd), .spi_miso(spi_miso));

  // 100 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask

  task automatic cmd(input logic [7:0] b);
    i_mcu.xfer(b, stat);
    tick(1);
  endtask

  task automatic done(input string name);
    $display("test %s done", name);
  endtask

  task automatic end_of_test();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // bounded wait for reset (sel 0) or interrupt (sel 1) to reach a level
  task automatic wait_on(input int sel, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    n_compared++;
    while (((sel == 0) ? rst_out_n : int_n) !== lvl) begin
      if (cnt >= lim) begin
        miscompares++;
        $display("wrong value %s expected %h seen %h", sel ? "int_n" : "rst_out_n", lvl, ~lvl);
        end_of_test();
      end
      tick(1);
      cnt++;
    end
  endtask

  initial begin
    reset_n = 1'b0;
    short_reset_variant = 1'b1;
    vdd_ok = 1'b1;
    vdd_overcurrent = 1'b0;
    temp_prewarn = 1'b0;
    temp_shutdown = 1'b0;
    can_bus_dominant = 1'b0;
    level_wake_inputs = 4'h0;
    // two power-ups: short strap, then standard strap
    for (int v = 0; v < 2; v++) begin
      reset_n = 1'b0;
      short_reset_variant = (v == 0);
      tick(8);
      `SBC_CHECK("rst in reset", 1'b0, rst_out_n)
      `SBC_CHECK("rxd in reset", 1'b1, can_rxd)
      reset_n = 1'b1;
      wait_on(0, 1'b1, 260, n);
      `SBC_CHECK("reset length", 1'b1, n >= (v ? 200 : 50) && n <= (v ? 210 : 60))
    end
    cmd(8'h81);
    `SBC_CHECK("status", 8'h20, stat)
    // a frame cut short: miso driven only while selected
    i_mcu.spi_cs_n = 1'b0;
    tick(5);
    `SBC_CHECK("miso enable", 1'b1, spi_miso_oe)
    i_mcu.spi_cs_n = 1'b1;
    tick(5);
    `SBC_CHECK("miso release", 1'b0, spi_miso_oe)
    done("power-up");
    // output commands with every transmit/bus combination
    foreach (rows[i]) begin
      cmd(rows[i].cmd);
      `SBC_CHECK("high side", rows[i].hs, high_side_switch)
      `SBC_CHECK("aux drive", rows[i].aux, aux_regulator_drive)
      i_mcu.can_txd = rows[i].txd;
      can_bus_dominant = rows[i].bus;
      tick(6);
      `SBC_CHECK("tx drive", ~rows[i].txd, can_drive_dominant)
      `SBC_CHECK("rxd", ~rows[i].bus, can_rxd)
      i_mcu.can_txd = 1'b1;
      can_bus_dominant = 1'b0;
      tick(2);
    end
    done("table");
    cmd(8'h81);
    i_mcu.can_txd = 1'b0;
    tick(10);
    `SBC_CHECK("dom start", 1'b1, can_drive_dominant)
    tick(45);
    `SBC_CHECK("dom timeout", 1'b0, can_drive_dominant)
    i_mcu.can_txd = 1'b1;
    tick(5);
    i_mcu.can_txd = 1'b0;
    tick(8);
    `SBC_CHECK("dom again", 1'b1, can_drive_dominant)
    i_mcu.can_txd = 1'b1;
    done("dominant timeout");
    // clear while the source persists must not drop the interrupt
    cmd(8'hc1);
    temp_prewarn = 1'b1;
    tick(6);
    `SBC_CHECK("prewarn", 1'b1, prewarn_flag)
    `SBC_CHECK("int level", 1'b0, int_n)
    cmd(8'hc9);
    `SBC_CHECK("status warn", 8'h30, stat)
    `SBC_CHECK("int held", 1'b0, int_n)
    temp_prewarn = 1'b0;
    cmd(8'hc8);
    `SBC_CHECK("int cleared", 1'b1, int_n)
    done("interrupt");
    // stop wakes: level input, bus activity, over-current after a short glitch
    for (int k = 0; k < 3; k++) begin
      cmd(8'h03);
      if (k == 2) begin
        vdd_overcurrent = 1'b1;
        tick(10);
        vdd_overcurrent = 1'b0;
        tick(30);
        `SBC_CHECK("glitch ignored", 1'b1, int_n)
      end
      if (k == 0) level_wake_inputs = 4'h1;
      can_bus_dominant = (k == 1);
      vdd_overcurrent = (k == 2);
      // level filter runs at its full default length
      wait_on(1, 1'b0, (k == 0) ? 2100 : 60, n);
      can_bus_dominant = 1'b0;
      vdd_overcurrent = 1'b0;
      `SBC_CHECK("no reset", 1'b1, rst_out_n)
      if (k == 2) `SBC_CHECK("deglitch", 1'b1, n >= 18)
      tick(1100);
      `SBC_CHECK("pulse over", 1'b1, int_n)
      cmd(8'h81);
      `SBC_CHECK("woken mode", 3'h1, stat[7:5])
    end
    done("stop wake");
    // window mode: an early trigger is a failure
    cmd(8'h86);
    cmd(8'h81);
    wait_on(0, 1'b0, 20, n);
    tick(2);
    `SBC_CHECK("wdog early", 1'b0, wdog_n)
    wait_on(0, 1'b1, 260, n);
    tick(1050);
    cmd(8'h81);
    `SBC_CHECK("wdog ok", 1'b1, wdog_n)
    cmd(8'h84);
    tick(2050);
    `SBC_CHECK("wdog timeout", 1'b0, rst_out_n)
    wait_on(0, 1'b1, 260, n);
    done("watchdog");
    // sleep: regulator and switches off, reset stays high; bus wake goes via reset
    cmd(8'h43);
    cmd(8'h02);
    tick(4);
    `SBC_CHECK("sleep regulator", 1'b0, vdd_enable)
    `SBC_CHECK("sleep high side", 1'b0, high_side_switch)
    `SBC_CHECK("sleep reset", 1'b1, rst_out_n)
    can_bus_dominant = 1'b1;
    wait_on(0, 1'b0, 20, n);
    can_bus_dominant = 1'b0;
    wait_on(0, 1'b1, 260, n);
    `SBC_CHECK("sleep woken", 1'b1, vdd_enable)
    done("sleep");
    vdd_ok = 1'b0;
    wait_on(0, 1'b0, 10, n);
    vdd_ok = 1'b1;
    wait_on(0, 1'b1, 260, n);
    `SBC_CHECK("uv restart", 1'b1, n >= 200)
    temp_shutdown = 1'b1;
    tick(6);
    `SBC_CHECK("regulator off", 1'b0, vdd_enable)
    `SBC_CHECK("shutdown reset", 1'b0, rst_out_n)
    done("supply");
    end_of_test();
  end
endmodule
